/* shared/adc_conversion_control_defs.vh */
`ifndef ADC_CONVERSION_CONTROL_DEFS_VH
`define ADC_CONVERSION_CONTROL_DEFS_VH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define ADC_CONTROL_STATUS_INDEX 8'h45
`define ADC_RESULT_HIGH_INDEX 8'h46
`define ADC_RESULT_LOW_INDEX 8'h47

// ----------------------------------------------------------------
// control/status field positions
// ----------------------------------------------------------------
`define CSR_EOC_BIT 7
`define CSR_SPEED_BIT 6
`define CSR_ON_BIT 5
`define CSR_SLOW_BIT 4
`define CSR_CHAN_MSB 3
`define CSR_CHAN_LSB 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CSR_RESET 8'h00
`define RESULT_HIGH_RESET 8'h00
`define RESULT_LOW_RESET 2'h0
`define SAR_RESET 10'h000

// ----------------------------------------------------------------
// conversion timing in converter-clock ticks, and the top bit index of the result
// ----------------------------------------------------------------
`define SAMPLE_TICKS 4'h4
`define BIT_TICKS 4'h6
`define SAR_TOP_BIT 4'h9

// ----------------------------------------------------------------
// wake-up stabilisation after halt
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define STAB_TIME_NS 10000
`define STAB_CYCLES ((`STAB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* verilog/adc_conversion_control.v */
`timescale 1ns/10ps
`include "adc_conversion_control_defs.vh"

module adc_conversion_control (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire halt_mode,
  input wire comparator_above,
  output reg [3:0] channel_select,
  output reg [9:0] dac_code,
  output reg sample_enable,
  output reg converter_power
);

  // ----------------------------------------------------------------
  // states and constants
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_STAB = 2'd1;
  localparam [1:0] ST_SAMPLE = 2'd2;
  localparam [1:0] ST_CONVERT = 2'd3;
  // the wake wait is worked out in 32-bit arithmetic; only the low 16 bits are kept
  localparam integer STAB_COUNT_FULL = `STAB_CYCLES;
  localparam [15:0] STAB_COUNT = STAB_COUNT_FULL[15:0];
  localparam [1:0] REG_NONE = 2'd0;
  localparam [1:0] REG_CSR = 2'd1;
  localparam [1:0] REG_HIGH = 2'd2;
  localparam [1:0] REG_LOW = 2'd3;

  // maps a bus address onto one of the three registers
  // only the three word addresses decode; anything else reads zero and drops writes
  function [1:0] reg_decode;
    input [31:0] addr;
    begin
      if (addr[31:10] != 22'h0 || addr[1:0] != 2'b00) begin
        reg_decode = REG_NONE;
      end else if (addr[9:2] == `ADC_CONTROL_STATUS_INDEX) begin
        reg_decode = REG_CSR;
      end else if (addr[9:2] == `ADC_RESULT_HIGH_INDEX) begin
        reg_decode = REG_HIGH;
      end else if (addr[9:2] == `ADC_RESULT_LOW_INDEX) begin
        reg_decode = REG_LOW;
      end else begin
        reg_decode = REG_NONE;
      end
    end
  endfunction

  // last value of the divider count for {slow, speed}
  function [1:0] div_last;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: div_last = 2'd1; // cpu / 2
        2'b01: div_last = 2'd0; // cpu undivided
        2'b10: div_last = 2'd3; // cpu / 4
        default: div_last = 2'd1; // cpu / 2 again
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg eoc_reg; // end-of-conversion flag
  reg speed_reg; // fast clock select
  reg converter_on_reg; // converter enable
  reg slow_reg; // slow clock select
  reg [3:0] channel_reg; // selected input
  reg [7:0] result_high_reg; // result bits 9..2
  reg [1:0] result_low_reg; // result bits 1..0
  reg lock_reg; // result pair held for the reader
  reg [1:0] wr_sel_reg; // pending write target
  reg [1:0] rd_sel_reg; // pending read target
  reg rd_pend_reg; // read in its wait state

  // ----------------------------------------------------------------
  // converter state
  // ----------------------------------------------------------------
  reg [1:0] state_reg;
  reg [1:0] div_cnt_reg; // converter clock divider
  reg [3:0] tick_cnt_reg; // ticks within sample or bit
  reg [3:0] bit_idx_reg; // bit under trial
  reg [9:0] sar_reg; // successive approximation word
  reg [15:0] stab_cnt_reg; // wake-up wait
  reg halted_reg; // set while halted, drives the wake wait
  reg cmp_s1_reg; // comparator synchroniser stages
  reg cmp_s2_reg;
  reg cmp_s3_reg;
  reg cmp_filt_reg; // comparator level after agreement

  // ----------------------------------------------------------------
  // bus decode and register side effects
  // ----------------------------------------------------------------
  // side effects of an access act at the end of its first data-phase cycle (a read's wait state), so the flag,
  // the lock and the csr all move on the same edge
  wire addr_phase = hsel & hready & htrans[1];
  wire wr_csr = (wr_sel_reg == REG_CSR);
  wire rd_high = rd_pend_reg & (rd_sel_reg == REG_HIGH);
  wire rd_low = rd_pend_reg & (rd_sel_reg == REG_LOW);
  wire chan_change = wr_csr & (hwdata[`CSR_CHAN_MSB:`CSR_CHAN_LSB] != channel_reg);
  wire turn_off = wr_csr & ~hwdata[`CSR_ON_BIT];
  // any of these kills the conversion under way
  wire abort = chan_change | turn_off | ~converter_on_reg | halt_mode;
  wire adc_tick = (div_cnt_reg == div_last({slow_reg, speed_reg}));
  wire bit_done = (state_reg == ST_CONVERT) & adc_tick & (tick_cnt_reg == `BIT_TICKS - 4'h1);
  wire conv_done = bit_done & (bit_idx_reg == 4'h0) & ~abort;
  // last bit decided from the comparator; a pinned comparator gives all ones or zero
  wire [9:0] sar_final = {sar_reg[9:1], cmp_filt_reg};
  wire [3:0] bit_next = bit_idx_reg - 4'h1;

  // ----------------------------------------------------------------
  // ahb-lite slave: writes zero wait, reads one wait state
  // ----------------------------------------------------------------
  // reads wait one cycle so a write just before is already visible
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_sel_reg <= REG_NONE;
      rd_sel_reg <= REG_NONE;
      rd_pend_reg <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
    end else if (clk_en) begin
      hresp <= 1'b0; // always okay
      if (rd_pend_reg) begin
        // data phase wait over, answer now
        rd_pend_reg <= 1'b0;
        hreadyout <= 1'b1;
        case (rd_sel_reg)
          REG_CSR: hrdata <= {24'h0, eoc_reg, speed_reg, converter_on_reg, slow_reg, channel_reg};
          REG_HIGH: hrdata <= {24'h0, result_high_reg};
          REG_LOW: hrdata <= {24'h0, 6'h00, result_low_reg};
          default: hrdata <= 32'h0; // unmapped reads zero
        endcase
      end else begin
        hrdata <= 32'h0;
      end
      if (addr_phase && !hwrite) begin
        rd_sel_reg <= reg_decode(haddr);
        rd_pend_reg <= 1'b1;
        hreadyout <= 1'b0;
      end
      if (addr_phase && hwrite) begin
        wr_sel_reg <= reg_decode(haddr);
      end else if (hready) begin
        wr_sel_reg <= REG_NONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // control/status register
  // ----------------------------------------------------------------
  // result registers are read only: writes to them are dropped
  // a write with an unchanged channel keeps the conversion under way; only a
  // new channel or clearing converter_on starts over
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed_reg <= 1'b0;
      converter_on_reg <= 1'b0;
      slow_reg <= 1'b0;
      channel_reg <= 4'h0;
      channel_select <= 4'h0;
    end else if (clk_en) begin
      if (wr_csr) begin
        // end flag bit of the write is ignored here
        speed_reg <= hwdata[`CSR_SPEED_BIT];
        converter_on_reg <= hwdata[`CSR_ON_BIT];
        slow_reg <= hwdata[`CSR_SLOW_BIT];
        channel_reg <= hwdata[`CSR_CHAN_MSB:`CSR_CHAN_LSB];
        channel_select <= hwdata[`CSR_CHAN_MSB:`CSR_CHAN_LSB];
      end
    end
  end

  // ----------------------------------------------------------------
  // end flag, lock and result registers
  // ----------------------------------------------------------------
  // completion wins over a clear in the same cycle
  // a clear from a high read or csr write that meets a completion is lost, so a
  // finished result is never hidden behind a clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eoc_reg <= 1'b0;
      lock_reg <= 1'b0;
      result_high_reg <= `RESULT_HIGH_RESET;
      result_low_reg <= `RESULT_LOW_RESET;
    end else if (clk_en) begin
      if (conv_done) begin
        eoc_reg <= 1'b1;
      end else if (rd_high || wr_csr) begin
        eoc_reg <= 1'b0;
      end
      if (rd_high || turn_off) begin
        lock_reg <= 1'b0;
      end else if (rd_low) begin
        lock_reg <= 1'b1;
      end
      // held while locked; the reader gets a matched pair
      // a low read takes its byte at this very edge, so a completion in that
      // cycle is held back too; otherwise the pair would mix two samples
      if (conv_done && !lock_reg && !rd_low) begin
        result_high_reg <= sar_final[9:2];
        result_low_reg <= sar_final[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // comparator synchroniser: the analog level is asynchronous
  // ----------------------------------------------------------------
  // the first stage may go metastable and only the second reads it; a level is
  // taken once stages two and three agree, so a one-cycle glitch between trial
  // words cannot flip a decided bit
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
      cmp_s3_reg <= 1'b0;
      cmp_filt_reg <= 1'b0;
    end else if (clk_en) begin
      cmp_s1_reg <= comparator_above;
      cmp_s2_reg <= cmp_s1_reg;
      cmp_s3_reg <= cmp_s2_reg;
      // take a level only once two stages agree
      if (cmp_s2_reg == cmp_s3_reg) begin
        cmp_filt_reg <= cmp_s3_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // converter clock divider
  // ----------------------------------------------------------------
  // undivided mode is only valid up to 4 MHz cpu; not enforced here
  // the count restarts if the selection shrinks under it, so a mode change
  // never strands the counter above its new last value
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_reg <= 2'd0;
    end else if (clk_en) begin
      if (adc_tick || div_cnt_reg > div_last({slow_reg, speed_reg})) begin
        div_cnt_reg <= 2'd0;
      end else begin
        div_cnt_reg <= div_cnt_reg + 2'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  // one conversion: an idle cycle, four sample ticks, then ten trials of six
  // ticks each, msb first, and then straight back to sampling
  // the comparator answer needs seven cpu cycles from a new trial word through the synchroniser,
  // so each undivided trial of six ticks is decided one cycle before its answer arrives; a slower comparator
  // would need more bit ticks
  // no wait-mode input: cpu wait has no say here
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      tick_cnt_reg <= 4'h0;
      bit_idx_reg <= `SAR_TOP_BIT;
      sar_reg <= `SAR_RESET;
      stab_cnt_reg <= 16'h0;
      halted_reg <= 1'b0;
      dac_code <= `SAR_RESET;
      sample_enable <= 1'b0;
      converter_power <= 1'b0;
    end else if (clk_en) begin
      converter_power <= converter_on_reg & ~halt_mode;
      dac_code <= sar_reg;
      sample_enable <= (state_reg == ST_SAMPLE) & ~abort;
      if (halt_mode) begin
        halted_reg <= 1'b1;
      end
      if (abort) begin
        // restart cleanly; a channel change or new enable starts over
        state_reg <= ST_IDLE;
        tick_cnt_reg <= 4'h0;
        sar_reg <= `SAR_RESET;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            tick_cnt_reg <= 4'h0;
            stab_cnt_reg <= 16'h0;
            if (halted_reg) begin
              state_reg <= ST_STAB;
            end else begin
              state_reg <= ST_SAMPLE;
            end
          end
          ST_STAB: begin
            // results before this point would be inaccurate
            if (stab_cnt_reg >= STAB_COUNT - 16'h1) begin
              halted_reg <= 1'b0;
              state_reg <= ST_SAMPLE;
            end else begin
              stab_cnt_reg <= stab_cnt_reg + 16'h1;
            end
          end
          ST_SAMPLE: begin
            if (adc_tick) begin
              if (tick_cnt_reg == `SAMPLE_TICKS - 4'h1) begin
                tick_cnt_reg <= 4'h0;
                bit_idx_reg <= `SAR_TOP_BIT;
                sar_reg <= 10'h200; // first trial: msb only
                state_reg <= ST_CONVERT;
              end else begin
                tick_cnt_reg <= tick_cnt_reg + 4'h1;
              end
            end
          end
          ST_CONVERT: begin
            if (adc_tick) begin
              if (tick_cnt_reg == `BIT_TICKS - 4'h1) begin
                tick_cnt_reg <= 4'h0;
                sar_reg[bit_idx_reg] <= cmp_filt_reg; // keep bit if input above trial
                if (bit_idx_reg == 4'h0) begin
                  state_reg <= ST_SAMPLE; // back to back on same channel
                end else begin
                  sar_reg[bit_next] <= 1'b1;
                  bit_idx_reg <= bit_next;
                end
              end else begin
                tick_cnt_reg <= tick_cnt_reg + 4'h1;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // adc_conversion_control

/* verification/adc_conversion_control_props.sv */
`timescale 1ns/10ps
`include "adc_conversion_control_defs.vh"
// ----------------------------------------------------------------
// port checks, written for clk_en held high
// ----------------------------------------------------------------
module adc_conversion_control_props (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire halt_mode,
  input wire [3:0] channel_select,
  input wire sample_enable,
  input wire [9:0] dac_code,
  input wire converter_power
);
  localparam [31:0] CSR_A = 32'h4 * `ADC_CONTROL_STATUS_INDEX;
  localparam [31:0] HIGH_A = 32'h4 * `ADC_RESULT_HIGH_INDEX;
  localparam [31:0] LOW_A = 32'h4 * `ADC_RESULT_LOW_INDEX;
  wire req = hsel && hready && htrans[1]; // address phase taken
  wire rd_req = req && !hwrite;
  reg wr_pend; // csr write in its data phase
  reg [3:0] wchan; // channel field of the last csr write
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // capture the write data; it only stands in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wchan <= 4'h0;
    end else begin
      wr_pend <= req && hwrite && (haddr == CSR_A);
      if (wr_pend) wchan <= hwdata[3:0];
    end
  end
  read_wait_a: assert property (rd_req |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  write_nowait_a: assert property (req && hwrite |=> hreadyout) else $error("write stalled");
  low_zero_a: assert property (rd_req && haddr == LOW_A |-> ##2 hrdata[31:2] == 30'h0)
    else $error("low result upper bits set");
  high_width_a: assert property (rd_req && haddr == HIGH_A |-> ##2 hrdata[31:8] == 24'h0)
    else $error("high result too wide");
  csr_width_a: assert property (rd_req && haddr == CSR_A |-> ##2 hrdata[31:8] == 24'h0)
    else $error("csr too wide");
  chan_follow_a: assert property (wr_pend |=> ##[0:2] channel_select == wchan)
    else $error("channel select not updated");
  off_power_a: assert property (wr_pend && !hwdata[5] |-> ##[1:3] !converter_power)
    else $error("converter still powered");
  on_power_a: assert property (wr_pend && hwdata[5] && !halt_mode ##1 !halt_mode |-> ##[0:2] converter_power)
    else $error("converter not powered");
  halt_power_a: assert property (halt_mode |=> !converter_power) else $error("powered in halt");
  resp_okay_a: assert property (hresp == 1'b0) else $error("error response on bus");
  off_nosample_a: assert property (!converter_power |-> !sample_enable) else $error("sampling while off");
  off_dac_zero_a: assert property (!converter_power ##1 !converter_power |-> dac_code == 10'h000)
    else $error("trial word left while off");
endmodule // adc_conversion_control_props

bind adc_conversion_control adc_conversion_control_props i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .halt_mode(halt_mode), .channel_select(channel_select),
  .sample_enable(sample_enable), .dac_code(dac_code), .converter_power(converter_power));

/* verification/analog_source.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// analog inputs and comparator facing the converter
// ----------------------------------------------------------------
module analog_source (
  input wire hclk,
  input wire converter_power,
  input wire [3:0] channel_select,
  input wire [9:0] dac_code,
  output reg comparator_above
);
  reg [10:0] level [0:15]; // per-channel input; 400h stands above the top reference
  integer k;
  initial begin
    comparator_above = 1'b0;
    for (k = 0; k < 16; k = k + 1) level[k] = 11'h000;
  end
  // pins are plain inputs, no pull and no pin interrupt, so only the level counts
  // an unpowered comparator gives no steady answer, so it toggles
  always @(posedge hclk) begin
    if (converter_power) comparator_above <= level[channel_select] >= {1'b0, dac_code};
    else comparator_above <= ~comparator_above;
  end
endmodule // analog_source

/* verification/tb_adc_conversion_control.sv */
`timescale 1ns/10ps
`include "adc_conversion_control_defs.vh"
module tb_adc_conversion_control;
  localparam [31:0] CSR_A = 32'h4 * `ADC_CONTROL_STATUS_INDEX;
  localparam [31:0] HIGH_A = 32'h4 * `ADC_RESULT_HIGH_INDEX;
  localparam [31:0] LOW_A = 32'h4 * `ADC_RESULT_LOW_INDEX;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, halt_mode = 1'b0;
  logic clk_en = 1'b1; // freezes the block while low
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, csrv;
  logic [1:0] htrans = 2'h0, sp;
  wire [31:0] hrdata;
  wire hreadyout, hresp, comparator_above, sample_enable, converter_power;
  wire [3:0] channel_select;
  wire [9:0] dac_code;
  logic [15:0] seed = 16'h388c; // 14476
  logic [3:0] ch = 4'h0;
  logic [10:0] lv;
  integer num_errors = 0, checked = 0, cycles = 0, i;
  always #20 hclk = ~hclk; // 25 MHz
  adc_conversion_control i_adc_conversion_control (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .halt_mode(halt_mode),
    .comparator_above(comparator_above), .channel_select(channel_select), .dac_code(dac_code),
    .sample_enable(sample_enable), .converter_power(converter_power));
  analog_source i_analog_source (.hclk(hclk), .converter_power(converter_power), .channel_select(channel_select),
    .dac_code(dac_code), .comparator_above(comparator_above));
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // saturate: above the top reference reads as all ones
  function [9:0] conv(input [10:0] l);
    conv = l[10] ? 10'h3ff : l[9:0];
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // single transfer: hold address until hready, then data until hready
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hready_q() !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready_q() !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  function logic hready_q();
    hready_q = hreadyout;
  endfunction
  // poll the end flag under a bound
  task wait_eoc;
    integer n;
    logic [31:0] r;
    n = 0;
    r = 32'h0;
    while (r[7] !== 1'b1 && n < 300) begin
      ahb(1'b0, CSR_A, 32'h0, r);
      n = n + 1;
    end
    check({31'h0, r[7]}, 32'h1);
  endtask
  task read_pair(input logic [10:0] l);
    ahb(1'b0, LOW_A, 32'h0, rd);
    check(rd, {22'h0, conv(l) & 10'h3});
    ahb(1'b0, HIGH_A, 32'h0, rd);
    check(rd, {22'h0, conv(l)} >> 2);
  endtask
  // hang guard
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors = num_errors + 1;
      print_verdict;
    end
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, refused writes and an unmapped address
    ahb(1'b0, CSR_A, 32'h0, rd); check(rd, 32'h0);
    read_pair(11'h000);
    ahb(1'b1, HIGH_A, 32'hff, rd); ahb(1'b0, HIGH_A, 32'h0, rd); check(rd, 32'h0);
    ahb(1'b0, 32'h120, 32'h0, rd); check(rd, 32'h0);
    ahb(1'b1, CSR_A, 32'h80, rd); ahb(1'b0, CSR_A, 32'h0, rd); check(rd, 32'h0);
    // each pass changes channel, so the write aborts and restarts
    for (i = 0; i < 8; i = i + 1) begin
      seed = lfsr(seed);
      ch = ch ^ (seed[3:0] | 4'h1);
      lv = (i == 0) ? 11'h7ff : (i == 1) ? 11'h000 : {1'b0, seed[15:6]};
      sp = (seed[5:4] == 2'b01) ? 2'b10 : seed[5:4]; // undivided clock is too fast at 25 MHz
      i_analog_source.level[ch] <= lv;
      csrv = {24'h0, 1'b0, sp[0], 1'b1, sp[1], ch};
      ahb(1'b1, CSR_A, csrv, rd);
      wait_eoc;
      read_pair(lv);
      ahb(1'b0, CSR_A, 32'h0, rd); check(rd, csrv);
    end
    // lock held across a completion, released by the high read
    ch = ch ^ 4'h1;
    i_analog_source.level[ch] <= 11'h155;
    csrv = {24'h0, 8'h20 | {4'h0, ch}};
    ahb(1'b1, CSR_A, csrv, rd);
    wait_eoc;
    ahb(1'b0, LOW_A, 32'h0, rd); check(rd, 32'h1);
    i_analog_source.level[ch] <= 11'h2aa;
    ahb(1'b1, CSR_A, csrv, rd);
    ahb(1'b0, CSR_A, 32'h0, rd); check(rd, csrv);
    wait_eoc;
    ahb(1'b0, HIGH_A, 32'h0, rd); check(rd, 32'h55);
    wait_eoc;
    read_pair(11'h2aa);
    // converter off: no completion follows
    ahb(1'b1, CSR_A, csrv & 32'hdf, rd);
    repeat (400) @(posedge hclk);
    ahb(1'b0, CSR_A, 32'h0, rd); check(rd, csrv & 32'hdf);
    // fast clock bit alone, converter off: it must read back
    ahb(1'b1, CSR_A, 32'h40 | {28'h0, ch}, rd);
    ahb(1'b0, CSR_A, 32'h0, rd); check(rd, 32'h40 | {28'h0, ch});
    // halt stops conversions; they resume after wake-up
    ahb(1'b1, CSR_A, csrv, rd);
    halt_mode <= 1'b1;
    repeat (400) @(posedge hclk);
    ahb(1'b0, CSR_A, 32'h0, rd); check(rd, csrv);
    halt_mode <= 1'b0;
    wait_eoc;
    read_pair(11'h2aa);
    // clock enable low: a fresh conversion cannot finish while frozen
    ch = ch ^ 4'h2;
    seed = lfsr(seed);
    lv = {1'b0, seed[15:6]};
    i_analog_source.level[ch] <= lv;
    csrv = {24'h0, 8'h20 | {4'h0, ch}};
    ahb(1'b1, CSR_A, csrv, rd);
    repeat (4) @(posedge hclk);
    clk_en <= 1'b0;
    repeat (400) @(posedge hclk);
    clk_en <= 1'b1;
    ahb(1'b0, CSR_A, 32'h0, rd); check(rd, csrv);
    // eight-bit read: the high byte alone clears the end flag
    wait_eoc;
    ahb(1'b0, HIGH_A, 32'h0, rd); check(rd, {22'h0, conv(lv)} >> 2);
    ahb(1'b0, CSR_A, 32'h0, rd); check(rd, csrv);
    print_verdict;
  end
endmodule // tb_adc_conversion_control
